// ### glpc_board.sv
// glpc_board: board side of the pins, with pull-ups, drivers and rom data line
// assumes the design drives a pin only while its enable is high
// ============================================================
// board model
module glpc_board (
    // design pin side
    input wire logic [2:0] gpio_out_in,
    input wire logic [2:0] gpio_oe_in,
    input wire logic rom_out_in,
    input wire logic rom_oe_in,
    // board drivers
    input wire logic [2:0] drv_oe_in,
    input wire logic [2:0] drv_val_in,
    input wire logic rom_val_in,
    // resolved levels
    output logic [2:0] gpio_pin_out,
    output logic rom_pin_out
);
    // pull-up holds a pin that nobody drives
    assign gpio_pin_out = (gpio_oe_in & gpio_out_in) | (~gpio_oe_in & ~drv_oe_in)
        | (~gpio_oe_in & drv_oe_in & drv_val_in);
    // rom answers whenever the data pin is released
    assign rom_pin_out = rom_oe_in ? rom_out_in : rom_val_in;
endmodule // glpc_board

// ### glpc_filt.sv
// ============================================================
// glpc_filt: per-bit minimum active time qualifier
// assumes synchronised inputs on the same clock
module glpc_filt #(
    parameter int WIDTH = 3,
    parameter int MIN_CYC = 1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // raw active levels and qualified levels
    input wire logic [WIDTH-1:0] act_in,
    output logic [WIDTH-1:0] ok_out
);
    localparam int CW = $clog2(MIN_CYC + 1);

    if (WIDTH < 1 || MIN_CYC < 1) begin : g_chk
        $error("glpc_filt: WIDTH and MIN_CYC must be at least 1");
    end

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic [CW-1:0] cnt;
        logic [CW-1:0] next_cnt;
        // saturating count of consecutive active samples
        assign next_cnt = !act_in[i] ? '0 :
                          (cnt == CW'(MIN_CYC)) ? cnt : CW'(cnt + 1'b1);
        always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
                cnt <= '0;
                ok_out[i] <= 1'b0;
            end else begin
                cnt <= next_cnt;
                ok_out[i] <= (next_cnt >= CW'(MIN_CYC));
            end
        end
    end
endmodule // glpc_filt

// ### glpc_pkg.sv
// ============================================================
// glpc_pkg: constants of the pin configuration block
// assumes a 10 MHz system clock and an AXI4-Lite byte address map
package glpc_pkg;
    // register byte offsets
    localparam logic [7:0] CFG_OFS = 8'h88;
    localparam logic [7:0] STS_OFS = 8'hC0;
    localparam logic [7:0] CLR_OFS = 8'hC4;
    localparam logic [7:0] ENA_OFS = 8'hC8;
    // reset value and writable bits of the configuration word
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [31:0] CFG_WMASK = 32'h7777_071F;
    localparam logic [31:0] PIN_DATA_MASK = 32'h0000_0007;
    // field positions
    localparam int LED_SEL_LSB = 28;
    localparam int IRQ_POL_LSB = 24;
    localparam int ROM_FN_LSB = 20;
    localparam int DRV_LSB = 16;
    localparam int DIR_LSB = 8;
    localparam int OOD_LSB = 3;
    localparam int PIN_DATA_LSB = 0;
    // rom pin function codes
    localparam logic [2:0] ROM_FN_ROM = 3'h0;
    localparam logic [2:0] ROM_FN_OUT34 = 3'h1;
    localparam logic [2:0] ROM_FN_RES2 = 3'h2;
    localparam logic [2:0] ROM_FN_O3_RXDV = 3'h3;
    localparam logic [2:0] ROM_FN_RES4 = 3'h4;
    localparam logic [2:0] ROM_FN_TXEN_O4 = 3'h5;
    localparam logic [2:0] ROM_FN_TXEN_RXDV = 3'h6;
    localparam logic [2:0] ROM_FN_CLKS = 3'h7;
    // timing: least active time of an interrupt level
    localparam int CLK_PERIOD_NS = 100;
    localparam int MIN_ACTIVE_NS = 40;
    localparam int MIN_ACTIVE_CYC_RAW = (MIN_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_ACTIVE_CYC = (MIN_ACTIVE_CYC_RAW < 1) ? 1 : MIN_ACTIVE_CYC_RAW;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### glpc_sync.sv
// ============================================================
// glpc_sync: two flip-flop synchroniser for a vector of levels
// assumes each bit is an independent level from another domain
module glpc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // levels
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta;

    if (WIDTH < 1) begin : g_chk
        $error("glpc_sync: WIDTH must be at least 1");
    end

    // first stage read only by the second
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta <= '0;
            q_out <= '0;
        end else begin
            meta <= d_in;
            q_out <= meta;
        end
    end
endmodule // glpc_sync

// ### glpc_top.sv
// ============================================================
// glpc_top: pin configuration register, shared pins, rom pin mux
// assumes AXI4-Lite master on CLK_IN; LED and rom sources on CLK_IN
// Functional notes
// R1 - a set indicator select bit makes its shared pin an LED output, clear makes it a pin.
// R2 - a pin's status bit sets while the pin sits at the level its polarity bit selects.
// R3 - a pin status reaches the interrupt output only when its enable bit is set.
// R4 - an active level must last longer than 40 ns to count, shorter pulses are dropped; the code counts a level sampled at one clock edge (MIN_CYC 1).
// R5 - a 3-bit field picks the rom data and clock pin functions, two codes reserved.
// R6 - software must not change that field mid rom cycle nor write reserved codes.
// R7 - a drive type bit of one gives push-pull, zero gives open-drain output.
// R8 - a direction bit of one makes the pin an output, zero an input.
// R9 - output-only pins 3 and 4 follow written bits 3 and 4.
// R10 - data bits drive output pins and read back the sampled pin state.
// R11 - reserved bits read zero and ignore writes.
// R12 - output-only bits reach the rom pins only in their mode, else the chosen signal.
//
// The AXI4-Lite register port was chosen for this implementation.
module glpc_top #(
    parameter int ADDR_W = 8,
    parameter int MIN_CYC = glpc_pkg::MIN_ACTIVE_CYC
) (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    // axi4-lite write address and data
    input wire logic AWVALID_IN,
    output logic AWREADY_OUT,
    input wire logic [ADDR_W-1:0] AWADDR_IN,
    input wire logic WVALID_IN,
    output logic WREADY_OUT,
    input wire logic [31:0] WDATA_IN,
    input wire logic [3:0] WSTRB_IN,
    // axi4-lite write response
    output logic BVALID_OUT,
    input wire logic BREADY_IN,
    output logic [1:0] BRESP_OUT,
    // axi4-lite read
    input wire logic ARVALID_IN,
    output logic ARREADY_OUT,
    input wire logic [ADDR_W-1:0] ARADDR_IN,
    output logic RVALID_OUT,
    input wire logic RREADY_IN,
    output logic [31:0] RDATA_OUT,
    output logic [1:0] RRESP_OUT,
    // shared led / general-purpose pins
    input wire logic [2:0] GPIO_IN,
    output logic [2:0] GPIO_OUT,
    output logic [2:0] GPIO_OE_OUT,
    input wire logic [2:0] LED_SRC_IN,
    // rom data and clock pins
    input wire logic ROM_DATA_IN,
    output logic ROM_DATA_OUT,
    output logic ROM_DATA_OE_OUT,
    output logic ROM_CLK_OUT,
    output logic ROM_CLK_OE_OUT,
    // serial rom controller side
    input wire logic ROM_DO_IN,
    input wire logic ROM_DOE_IN,
    input wire logic ROM_CLK_IN,
    output logic ROM_DI_OUT,
    // mii monitor signals
    input wire logic TX_EN_IN,
    input wire logic TX_CLK_IN,
    input wire logic RX_DV_IN,
    input wire logic RX_CLK_IN,
    // interrupt
    output logic IRQ_OUT
);
    if (ADDR_W < 8 || MIN_CYC < 1) begin : g_chk
        $error("glpc_top: ADDR_W must be >= 8 and MIN_CYC >= 1");
    end

    // ============================================================
    // state
    logic [31:0] cfg;
    logic [2:0] sts;
    logic [2:0] ena;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // ============================================================
    // input synchronisers and level qualifier
    logic [7:0] sync_q;
    logic [2:0] pin_s;
    logic rom_s;
    logic tx_en_s;
    logic tx_clk_s;
    logic rx_dv_s;
    logic rx_clk_s;
    logic [2:0] act;
    logic [2:0] filt_ok;

    glpc_sync #(.WIDTH(8)) u_sync (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .d_in({RX_CLK_IN, RX_DV_IN, TX_CLK_IN, TX_EN_IN, ROM_DATA_IN, GPIO_IN}),
        .q_out(sync_q)
    );
    assign pin_s = sync_q[2:0];
    assign rom_s = sync_q[3];
    assign tx_en_s = sync_q[4];
    assign tx_clk_s = sync_q[5];
    assign rx_dv_s = sync_q[6];
    assign rx_clk_s = sync_q[7];

    // ============================================================
    // configuration fields
    logic [2:0] led_sel;
    logic [2:0] pol;
    logic [2:0] rom_fn;
    logic [2:0] drv;
    logic [2:0] dir;
    logic [1:0] ood;
    logic [2:0] pin_data;
    assign led_sel = cfg[glpc_pkg::LED_SEL_LSB +: 3];
    assign pol = cfg[glpc_pkg::IRQ_POL_LSB +: 3];
    assign rom_fn = cfg[glpc_pkg::ROM_FN_LSB +: 3];
    assign drv = cfg[glpc_pkg::DRV_LSB +: 3];
    assign dir = cfg[glpc_pkg::DIR_LSB +: 3];
    assign ood = cfg[glpc_pkg::OOD_LSB +: 2];
    assign pin_data = cfg[glpc_pkg::PIN_DATA_LSB +: 3];

    // active when the pin matches its polarity
    assign act = ~(pin_s ^ pol); // R2

    glpc_filt #(.WIDTH(3), .MIN_CYC(MIN_CYC)) u_filt ( // R4
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .act_in(act),
        .ok_out(filt_ok)
    );

    // ============================================================
    // axi4-lite decode
    wire do_write = !AWREADY_OUT && !WREADY_OUT && !BVALID_OUT;
    wire do_read = ARVALID_IN && ARREADY_OUT;
    wire [5:0] w_idx = aw_addr[7:2];
    wire [5:0] r_idx = ARADDR_IN[7:2];
    wire w_cfg = w_idx == glpc_pkg::CFG_OFS[7:2];
    wire w_clr = w_idx == glpc_pkg::CLR_OFS[7:2];
    wire w_ena = w_idx == glpc_pkg::ENA_OFS[7:2];
    wire w_sts = w_idx == glpc_pkg::STS_OFS[7:2];
    wire w_hit = w_cfg || w_clr || w_ena || w_sts;
    wire r_cfg = r_idx == glpc_pkg::CFG_OFS[7:2];
    wire r_sts = r_idx == glpc_pkg::STS_OFS[7:2];
    wire r_ena = r_idx == glpc_pkg::ENA_OFS[7:2];
    wire r_clr = r_idx == glpc_pkg::CLR_OFS[7:2];
    wire r_hit = r_cfg || r_sts || r_ena || r_clr;
    wire [31:0] byte_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire [31:0] cfg_wmask = byte_mask & glpc_pkg::CFG_WMASK; // R11
    wire [31:0] next_cfg = (cfg & ~cfg_wmask) | (w_data & cfg_wmask);
    wire [2:0] clr_pulse = (do_write && w_clr && w_strb[0]) ? w_data[2:0] : 3'h0;

    // read value: data bits show sampled pins, reserved bits zero
    wire [31:0] cfg_rd = (cfg & glpc_pkg::CFG_WMASK & ~glpc_pkg::PIN_DATA_MASK)
                       | {29'h0, pin_s}; // R10
    wire [31:0] rd_mux = r_cfg ? cfg_rd :
                         r_sts ? {29'h0, sts} :
                         r_ena ? {29'h0, ena} : 32'h0000_0000;

    // write handshake: address and data taken independently
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            AWREADY_OUT <= 1'b1;
            WREADY_OUT <= 1'b1;
            BVALID_OUT <= 1'b0;
            BRESP_OUT <= glpc_pkg::RESP_OKAY;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (AWVALID_IN && AWREADY_OUT) begin
                AWREADY_OUT <= 1'b0;
                aw_addr <= AWADDR_IN;
            end
            if (WVALID_IN && WREADY_OUT) begin
                WREADY_OUT <= 1'b0;
                w_data <= WDATA_IN;
                w_strb <= WSTRB_IN;
            end
            if (do_write) begin
                BVALID_OUT <= 1'b1;
                BRESP_OUT <= w_hit ? glpc_pkg::RESP_OKAY : glpc_pkg::RESP_SLVERR;
            end
            if (BVALID_OUT && BREADY_IN) begin
                BVALID_OUT <= 1'b0;
                AWREADY_OUT <= 1'b1;
                WREADY_OUT <= 1'b1;
            end
        end
    end

    // read handshake: one read at a time
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            ARREADY_OUT <= 1'b1;
            RVALID_OUT <= 1'b0;
            RDATA_OUT <= 32'h0000_0000;
            RRESP_OUT <= glpc_pkg::RESP_OKAY;
        end else if (do_read) begin
            ARREADY_OUT <= 1'b0;
            RVALID_OUT <= 1'b1;
            RDATA_OUT <= rd_mux;
            RRESP_OUT <= r_hit ? glpc_pkg::RESP_OKAY : glpc_pkg::RESP_SLVERR;
        end else if (RVALID_OUT && RREADY_IN) begin
            ARREADY_OUT <= 1'b1;
            RVALID_OUT <= 1'b0;
        end
    end

    // ============================================================
    // registers written by software
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            cfg <= glpc_pkg::CFG_RST;
            ena <= 3'h0;
        end else if (do_write) begin
            if (w_cfg) begin
                cfg <= next_cfg; // R11
            end
            if (w_ena && w_strb[0]) begin
                ena <= w_data[2:0];
            end
        end
    end

    // ============================================================
    // sticky status, set wins over clear; led pins raise nothing
    wire [2:0] sts_set = filt_ok & ~led_sel; // R2
    wire [2:0] next_sts = (sts & ~clr_pulse) | sts_set;
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            sts <= 3'h0;
            IRQ_OUT <= 1'b0;
        end else begin
            sts <= next_sts;
            IRQ_OUT <= |(next_sts & ena); // R3
        end
    end

    // ============================================================
    // shared pin drivers
    logic [2:0] next_pin_out;
    logic [2:0] next_pin_oe;
    for (genvar i = 0; i < 3; i++) begin : g_pin
        // led: push-pull; output: push-pull or open-drain; input: released
        assign next_pin_oe[i] = led_sel[i] | (dir[i] & (drv[i] | ~pin_data[i])); // R8
        assign next_pin_out[i] = led_sel[i] ? LED_SRC_IN[i] : (drv[i] & pin_data[i]); // R7
    end
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            GPIO_OUT <= 3'h0;
            GPIO_OE_OUT <= 3'h0;
        end else begin
            GPIO_OUT <= next_pin_out; // R1
            GPIO_OE_OUT <= next_pin_oe; // R10
        end
    end

    // ============================================================
    // rom pin function decode
    wire fn_rom = rom_fn == glpc_pkg::ROM_FN_ROM;
    wire fn_o34 = rom_fn == glpc_pkg::ROM_FN_OUT34;
    wire fn_o3rx = rom_fn == glpc_pkg::ROM_FN_O3_RXDV;
    wire fn_txo4 = rom_fn == glpc_pkg::ROM_FN_TXEN_O4;
    wire fn_txrx = rom_fn == glpc_pkg::ROM_FN_TXEN_RXDV;
    wire fn_clks = rom_fn == glpc_pkg::ROM_FN_CLKS;
    wire dat_o3 = fn_o34 || fn_o3rx; // R12
    wire dat_txen = fn_txo4 || fn_txrx;
    wire clk_o4 = fn_o34 || fn_txo4; // R12
    wire clk_rxdv = fn_o3rx || fn_txrx;
    // reserved codes leave both pins undriven
    wire next_rom_dat = fn_rom ? ROM_DO_IN : dat_o3 ? ood[0] : dat_txen ? tx_en_s :
                        fn_clks ? tx_clk_s : 1'b0; // R5
    wire next_rom_dat_oe = fn_rom ? ROM_DOE_IN : (dat_o3 || dat_txen || fn_clks);
    wire next_rom_clk = fn_rom ? ROM_CLK_IN : clk_o4 ? ood[1] : clk_rxdv ? rx_dv_s :
                        fn_clks ? rx_clk_s : 1'b0; // R9
    wire next_rom_clk_oe = fn_rom || clk_o4 || clk_rxdv || fn_clks;
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            ROM_DATA_OUT <= 1'b0;
            ROM_DATA_OE_OUT <= 1'b0;
            ROM_CLK_OUT <= 1'b0;
            ROM_CLK_OE_OUT <= 1'b0;
            ROM_DI_OUT <= 1'b0;
        end else begin
            ROM_DATA_OUT <= next_rom_dat;
            ROM_DATA_OE_OUT <= next_rom_dat_oe;
            ROM_CLK_OUT <= next_rom_clk;
            ROM_CLK_OE_OUT <= next_rom_clk_oe;
            ROM_DI_OUT <= rom_s;
        end
    end

    // ============================================================
    // assertions
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    a_led_pin_drive: assert property ( // R1
        led_sel[0] |=> GPIO_OE_OUT[0] && GPIO_OUT[0] == $past(LED_SRC_IN[0]))
        else $error("led pin not driven from its source");

    a_irq_status_set: assert property ( // R2
        (filt_ok[0] && !led_sel[0]) |=> sts[0])
        else $error("status bit not set by qualified level");

    a_irq_enable_gate: assert property ( // R3
        IRQ_OUT |-> (sts & $past(ena)) != 3'h0)
        else $error("interrupt without enabled status");

    a_irq_disabled_low: assert property ( // R3
        (ena == 3'h0) |=> !IRQ_OUT)
        else $error("interrupt raised while all disabled");

    a_short_pulse_drop: assert property ( // R4
        filt_ok[0] |-> $past(act[0]))
        else $error("qualified level without active sample");

    a_rom_reserved_quiet: assert property ( // R5
        (rom_fn == glpc_pkg::ROM_FN_RES2 || rom_fn == glpc_pkg::ROM_FN_RES4)
        |=> !ROM_DATA_OE_OUT && !ROM_CLK_OE_OUT)
        else $error("rom pins driven under reserved code");

    a_open_drain_out: assert property ( // R7
        (!led_sel[0] && dir[0] && !drv[0]) |=> !GPIO_OUT[0] &&
        GPIO_OE_OUT[0] == !$past(pin_data[0]))
        else $error("open-drain pin driven high");

    a_input_released: assert property ( // R8
        (!led_sel[0] && !dir[0]) |=> !GPIO_OE_OUT[0])
        else $error("input pin driven");

    a_output_only_bits: assert property ( // R9
        fn_o34 |=> ROM_DATA_OE_OUT && ROM_DATA_OUT == $past(ood[0]) &&
        ROM_CLK_OUT == $past(ood[1]))
        else $error("output-only bits not on rom pins");

    a_data_readback: assert property ( // R10
        (do_read && r_cfg) |=> RDATA_OUT[2:0] == $past(pin_s))
        else $error("data bits do not show pin state");

    a_reserved_read_zero: assert property ( // R11
        (do_read && r_cfg) |=> (RDATA_OUT & ~glpc_pkg::CFG_WMASK) == 32'h0000_0000)
        else $error("reserved bits read nonzero");

    a_rom_alt_select: assert property ( // R12
        fn_txrx |=> ROM_DATA_OUT == $past(tx_en_s) && ROM_CLK_OUT == $past(rx_dv_s))
        else $error("alternate signals not on rom pins");

    c_cfg_write: cover property (do_write && w_cfg);
    c_irq_rise: cover property (!IRQ_OUT ##1 IRQ_OUT);
    c_rom_clks: cover property (fn_clks ##1 ROM_DATA_OE_OUT);
    c_set_on_clear: cover property (clr_pulse[0] && sts_set[0]);
endmodule // glpc_top

// ### gpio_led_pin_config_test.sv
// gpio_led_pin_config_test: self-checking bench of the pin configuration block
// assumes glpc_pkg, glpc_top and glpc_board are compiled first
// ============================================================
// bench top
module gpio_led_pin_config_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0;
    logic [2:0] led = 0, bo = 3'h7, bv = 0;
    logic rdo = 0, rdoe = 0, rck = 0, txe = 0, txc = 0, rxv = 0, rxc = 0, rv = 0;
    wire awr, wr, bval, arr, rval, irq, di, rout, roe, cout, coe, rpin;
    wire [1:0] br, rr;
    wire [31:0] rd;
    wire [2:0] go, goe, gpin;
    int n_mismatch = 0, checks = 0;
    logic [33:0] expq[$];
    // design and board
    glpc_top DUT (.CLK_IN(clk), .RST_N_IN(rst_n), .AWVALID_IN(awv), .AWREADY_OUT(awr),
        .AWADDR_IN(awa), .WVALID_IN(wv), .WREADY_OUT(wr), .WDATA_IN(wd), .WSTRB_IN(4'hF),
        .BVALID_OUT(bval), .BREADY_IN(bre), .BRESP_OUT(br), .ARVALID_IN(arv),
        .ARREADY_OUT(arr), .ARADDR_IN(ara), .RVALID_OUT(rval), .RREADY_IN(rre),
        .RDATA_OUT(rd), .RRESP_OUT(rr), .GPIO_IN(gpin), .GPIO_OUT(go), .GPIO_OE_OUT(goe),
        .LED_SRC_IN(led), .ROM_DATA_IN(rpin), .ROM_DATA_OUT(rout), .ROM_DATA_OE_OUT(roe),
        .ROM_CLK_OUT(cout), .ROM_CLK_OE_OUT(coe), .ROM_DO_IN(rdo), .ROM_DOE_IN(rdoe),
        .ROM_CLK_IN(rck), .ROM_DI_OUT(di), .TX_EN_IN(txe), .TX_CLK_IN(txc),
        .RX_DV_IN(rxv), .RX_CLK_IN(rxc), .IRQ_OUT(irq));
    glpc_board u_board (.gpio_out_in(go), .gpio_oe_in(goe), .rom_out_in(rout),
        .rom_oe_in(roe), .drv_oe_in(bo), .drv_val_in(bv), .rom_val_in(rv),
        .gpio_pin_out(gpin), .rom_pin_out(rpin));
    // 100 ns clock
    initial begin
        forever #50 clk = ~clk;
    end
    // ============================================================
    // checking and closing
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(string nm, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_up;
        n_mismatch++;
        $display("[FAIL] handshake expected within 100 cycles seen none");
        report_and_stop();
    endtask
    // read results against the oldest note
    always @(posedge clk) begin
        if (rval && rre) begin
            check("rdata", expq[0][31:0], rd);
            check("rresp", 32'(expq[0][33:32]), 32'(rr));
            void'(expq.pop_front());
        end
    end
    // ============================================================
    // bus tasks
    task automatic wr_reg(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
            if (n > 100) give_up();
        end while (!bval);
        bre <= 1'b0;
        check("bresp", 32'(er), 32'(br));
    endtask
    task automatic rd_reg(logic [7:0] a, logic [31:0] e, logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        expq.push_back({er, e});
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arr) arv <= 1'b0;
            if (n > 100) give_up();
        end while (!rval);
        rre <= 1'b0;
    endtask
    // ============================================================
    // main sequence
    initial begin
        logic [31:0] c, e;
        logic [2:0] oe, dr;
        logic [2:0] codes[6];
        logic ed, ec;
        codes = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
        void'($urandom(92));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        // reset value, reserved bits, led mode
        rd_reg(glpc_pkg::CFG_OFS, 32'h0, glpc_pkg::RESP_OKAY);
        wr_reg(glpc_pkg::CFG_OFS, 32'hFFFF_FFF8, glpc_pkg::RESP_OKAY);
        rd_reg(glpc_pkg::CFG_OFS, 32'h7777_0718, glpc_pkg::RESP_OKAY);
        led <= 3'($urandom);
        repeat (2) @(posedge clk);
        check("led_out", 32'(led), 32'(go));
        check("led_oe", 32'h7, 32'(goe));
        // direction, drive type and data
        for (int i = 0; i < 6; i++) begin
            c = $urandom & 32'h0707_0707;
            dr = c[10:8];
            bo <= ~dr;
            bv <= c[26:24];
            wr_reg(glpc_pkg::CFG_OFS, c & 32'h0007_0707, glpc_pkg::RESP_OKAY);
            repeat (4) @(posedge clk);
            oe = dr & (c[18:16] | ~c[2:0]);
            check("gpio_oe", 32'(oe), 32'(goe));
            check("gpio_out", 32'(c[2:0] & oe), 32'(go & oe));
            e = (c & 32'h0007_0700) | 32'((dr & c[2:0]) | (~dr & c[26:24]));
            rd_reg(glpc_pkg::CFG_OFS, e, glpc_pkg::RESP_OKAY);
        end
        // rom pin functions
        rdoe <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            c = $urandom;
            {rxc, rxv, txc, txe, rck, rdo} <= c[5:0];
            e = (32'(codes[k]) << 20) | (c & 32'h0000_0300) >> 5;
            wr_reg(glpc_pkg::CFG_OFS, e, glpc_pkg::RESP_OKAY);
            repeat (5) @(posedge clk);
            ed = (k == 0) ? c[0] : (k < 3) ? c[8] : (k < 5) ? c[2] : c[3];
            ec = (k == 0) ? c[1] : (k == 1 || k == 3) ? c[9] : (k < 5) ? c[4] : c[5];
            check("rom_data", 32'(ed), 32'(rout));
            check("rom_clk", 32'(ec), 32'(cout));
            check("rom_oe", 32'h3, 32'({roe, coe}));
        end
        rdoe <= 1'b0;
        rv <= 1'($urandom);
        wr_reg(glpc_pkg::CFG_OFS, 32'h0, glpc_pkg::RESP_OKAY);
        repeat (4) @(posedge clk);
        check("rom_di", 32'({1'b0, rv}), 32'({roe, di}));
        // pin interrupts: polarity, enable, short pulse, clear
        wr_reg(glpc_pkg::CFG_OFS, 32'h0500_0000, glpc_pkg::RESP_OKAY);
        bo <= 3'h7;
        bv <= 3'h2;
        wr_reg(glpc_pkg::ENA_OFS, 32'h7, glpc_pkg::RESP_OKAY);
        repeat (6) @(posedge clk);
        wr_reg(glpc_pkg::CLR_OFS, 32'h7, glpc_pkg::RESP_OKAY);
        @(posedge clk);
        #30 bv[0] <= 1'b1;
        #30 bv[0] <= 1'b0;
        repeat (6) @(posedge clk);
        check("irq_pulse", 32'h0, 32'(irq));
        rd_reg(glpc_pkg::STS_OFS, 32'h0, glpc_pkg::RESP_OKAY);
        for (int i = 0; i < 3; i++) begin
            bv <= 3'h2 ^ (3'h1 << i);
            repeat (6) @(posedge clk);
            check("irq_set", 32'h1, 32'(irq));
            rd_reg(glpc_pkg::STS_OFS, 32'h1 << i, glpc_pkg::RESP_OKAY);
            wr_reg(glpc_pkg::ENA_OFS, 32'h7 ^ (32'h1 << i), glpc_pkg::RESP_OKAY);
            repeat (3) @(posedge clk);
            check("irq_masked", 32'h0, 32'(irq));
            wr_reg(glpc_pkg::ENA_OFS, 32'h7, glpc_pkg::RESP_OKAY);
            bv <= 3'h2;
            repeat (6) @(posedge clk);
            wr_reg(glpc_pkg::CLR_OFS, 32'h1 << i, glpc_pkg::RESP_OKAY);
            rd_reg(glpc_pkg::STS_OFS, 32'h0, glpc_pkg::RESP_OKAY);
            check("irq_clear", 32'h0, 32'(irq));
        end
        // unmapped and one-way places
        wr_reg(8'h10, 32'hFFFF_FFFF, glpc_pkg::RESP_SLVERR);
        rd_reg(8'h10, 32'h0, glpc_pkg::RESP_SLVERR);
        wr_reg(glpc_pkg::STS_OFS, 32'h7, glpc_pkg::RESP_OKAY);
        rd_reg(glpc_pkg::STS_OFS, 32'h0, glpc_pkg::RESP_OKAY);
        rd_reg(glpc_pkg::CLR_OFS, 32'h0, glpc_pkg::RESP_OKAY);
        rd_reg(glpc_pkg::ENA_OFS, 32'h7, glpc_pkg::RESP_OKAY);
        repeat (3) @(posedge clk);
        report_and_stop();
    end
endmodule // gpio_led_pin_config_test
